// ---- bench/tb.sv ----
`timescale 1ns/1ns
`include "wsf_defs.vh"
module tb;
localparam integer FRAME = 900;
localparam [71:0] PAT = 72'hf62833445566778881;
reg         hclk = 1'b0;
reg         hresetn = 1'b0;
reg         hsel = 1'b0;
reg  [31:0] haddr = 32'h0;
reg  [1:0]  htrans = 2'h0;
reg         hwrite = 1'b0;
reg  [31:0] hwdata = 32'h0;
reg         ovh_sel = 1'b0;
reg         ovh_tx_data = 1'b0;
reg  [71:0] got;
integer     ph = 0;
integer     i;
integer     error_cnt = 0;
integer     check_count = 0;
wire        hreadyout;
wire        irq;
wire        tx_pcs_ready;
wire        tx_frame;
wire        ovh_rx_data;
wire        hresp;
wire        rx_frame;
wire        rx_pcs_valid;
wire [31:0] hrdata;
wire [7:0]  tx_pcs_data;
wire [7:0]  tx_pma_data;
wire [7:0]  rx_pma_data;
wire [7:0]  rx_pcs_data;
wsf_framer #(.STS_N(16'd4), .ROW_LEN(16'd100), .B1_LATCH_FRAMES(16'd2)) u_wsf_framer (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
  .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .tx_pcs_data, .tx_pcs_ready,
  .tx_pma_data, .rx_pma_data, .rx_pcs_data, .rx_pcs_valid,
  .tx_overhead_serial_port_sel(ovh_sel), .tx_overhead_serial_port_data(ovh_tx_data),
  .tx_overhead_serial_port_frame(tx_frame), .rx_overhead_serial_port_data(ovh_rx_data),
  .rx_overhead_serial_port_frame(rx_frame));
wsf_pcs_pma_model u_wsf_pcs_pma_model (.hclk, .hresetn, .tx_pcs_ready, .tx_pma_data,
  .tx_pcs_data, .rx_pma_data);
always #5 hclk = ~hclk;
////////////////////////////////////////////////////////////
// Serial overhead feed; phase predicted so bit 0 is ready at the pulse
always @(posedge hclk)
begin
  ph = tx_frame ? 1 : (ph == FRAME - 1 ? 0 : ph + 1);
  ovh_tx_data <= ph < 72 ? PAT[71 - ph] : 1'b0;
end
task finish_test;
begin
  $display("checks %0d errors %0d", check_count, error_cnt);
  if (error_cnt == 0 && check_count > 0)
    $display("All tests passed");
  else
    $display("Some tests failed");
  $finish;
end
endtask
task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
begin
  check_count = check_count + 1;
  if (seen !== exp)
  begin
    error_cnt = error_cnt + 1;
    $display("unexpected %0s exp %h seen %h", nm, exp, seen);
  end
end
endtask
// Sel 0 tx frame, 1 rx frame, 2 bus ready; returns at the edge it is seen
task wait_sig(input integer s);
integer n;
begin
  n = 0;
  @(posedge hclk);
  while ((s == 0 ? tx_frame : s == 1 ? rx_frame : hreadyout) !== 1'b1 && n < 2000)
  begin
    n = n + 1;
    @(posedge hclk);
  end
  if (n >= 2000)
  begin
    chk(0, 1, "timeout");
    finish_test;
  end
end
endtask
task wr(input [7:0] a, input [31:0] d);
begin
  hsel <= 1'b1;
  haddr <= {24'h0, a};
  hwrite <= 1'b1;
  htrans <= 2'h2;
  wait_sig(2);
  htrans <= 2'h0;
  hwdata <= d;
  wait_sig(2);
end
endtask
task rd(input [7:0] a, input [31:0] e, input [63:0] nm);
begin
  hsel <= 1'b1;
  haddr <= {24'h0, a};
  hwrite <= 1'b0;
  htrans <= 2'h2;
  wait_sig(2);
  htrans <= 2'h0;
  wait_sig(2);
  chk({31'h0, hresp}, 32'h0, "hresp");
  chk(hrdata, e, nm);
end
endtask
task row0(input [7:0] a1, input [7:0] a2, input [7:0] gr);
begin
  wait_sig(0);
  for (i = 0; i < 12; i = i + 1)
  begin
    @(posedge hclk);
    chk({24'h0, tx_pma_data}, {24'h0, i < 4 ? a1 : i < 8 ? a2 : i == 8 ? 8'h5a : gr}, "row0");
  end
end
endtask
////////////////////////////////////////////////////////////
initial
begin
  repeat (3) @(posedge hclk);
  hresetn <= 1'b1;
  rd(`WSF_REG_STATUS, 32'h0, "status");
  rd(`WSF_REG_FRAMING, 32'hf628, "framing");
  rd(`WSF_REG_GROWTH, 32'hcc00, "growth");
  rd(`WSF_REG_USERDCC, 32'h0, "userdcc");
  rd(`WSF_REG_DCCTAIL, 32'h0, "dcctail");
  rd(8'h28, 32'h0, "unmapped");
  chk({31'h0, rx_pcs_valid}, 32'h1, "bypass");
  wr(8'h40, 32'h5a);
  wr(`WSF_REG_CTRL, 32'h1);
  rd(`WSF_REG_STATUS, 32'h1, "status");
  row0(8'hf6, 8'h28, 8'hcc);
  repeat (3) wait_sig(0);
  wr(`WSF_REG_STATUS, 32'h0);
  rd(`WSF_REG_STATUS, 32'h3, "status");
  rd(8'h80, 32'h5a, "rxtrace");
  rd(`WSF_REG_POINTER, 32'h0, "pointer");
  // Only back-to-back valid bytes compared; overhead slots break the run
  for (i = 0; i < 60; i = i + 1)
  begin
    got[8:0] = {rx_pcs_valid, rx_pcs_data};
    wait_sig(3);
    if (got[8] && rx_pcs_valid)
      chk({24'h0, rx_pcs_data}, {24'h0, got[7:0] + 8'h01}, "payload");
  end
  // Wrong framing value drops receive lock, raising the loss event
  wr(`WSF_REG_INT_MASK, 32'h1);
  wr(`WSF_REG_FRAMING, 32'ha1b2);
  row0(8'ha1, 8'hb2, 8'hcc);
  repeat (6) wait_sig(0);
  chk({31'h0, irq}, 32'h1, "irq");
  wr(`WSF_REG_INT_MASK, 32'h0);
  @(posedge hclk);
  chk({31'h0, irq}, 32'h0, "irq");
  wr(`WSF_REG_FRAMING, 32'hf628);
  repeat (6) wait_sig(0);
  wr(`WSF_REG_INT_STAT, 32'h7);
  wr(`WSF_REG_INT_MASK, 32'h1);
  @(posedge hclk);
  chk({31'h0, irq}, 32'h0, "irq");
  ovh_sel <= 1'b1;
  repeat (4) wait_sig(0);
  row0(8'hf6, 8'h28, 8'h33);
  wait_sig(1);
  for (i = 0; i < 72; i = i + 1)
  begin
    got = {got[70:0], ovh_rx_data};
    if (i < 71)
      @(posedge hclk);
  end
  chk(got[71:40], PAT[71:40], "rx_overhead_serial_port");
  chk(got[39:8], PAT[39:8], "rx_overhead_serial_port");
  chk({24'h0, got[7:0]}, 32'h81, "b1mask");
  repeat (3) wait_sig(0);
  rd(`WSF_REG_B1CNT, 32'h4, "b1count");
  finish_test;
end
endmodule

// ---- bench/wsf_framer_properties.sv ----
`timescale 1ns/1ns
`include "wsf_defs.vh"
module wsf_framer_properties
#(
  parameter [15:0] STS_N = 16'd192
)
(
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        irq,
  input wire [7:0]  tx_pcs_data,
  input wire        tx_pcs_ready,
  input wire [7:0]  tx_pma_data,
  input wire [7:0]  rx_pma_data,
  input wire [7:0]  rx_pcs_data,
  input wire        rx_pcs_valid,
  input wire        tx_overhead_serial_port_frame,
  input wire        rx_overhead_serial_port_frame
);
localparam int RDY = 3 * STS_N + 1;
reg       wr_pend;
reg [7:0] wr_addr;
reg       en;
reg [2:0] msk;
////////////////////////////////////////////////////////////
// Shadow of enable and mask, written at the data phase
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    wr_pend <= 1'b0;
    wr_addr <= 8'h00;
    en      <= 1'b0;
    msk     <= 3'h0;
  end
  else
  begin
    wr_pend <= hsel && htrans[1] && hready && hwrite && haddr[31:8] == 24'h0;
    wr_addr <= haddr[7:0];
    if (wr_pend && wr_addr == `WSF_REG_CTRL)
      en <= hwdata[0];
    if (wr_pend && wr_addr == `WSF_REG_INT_MASK)
      msk <= hwdata[2:0];
  end
end
////////////////////////////////////////////////////////////
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
a_tx_bypass: assert property (
  $past(hresetn) && !$past(en) |-> tx_pma_data == $past(tx_pcs_data))
  else $error("tx bypass byte wrong");
a_rx_bypass: assert property (
  $past(hresetn) && !$past(en) |-> rx_pcs_valid && rx_pcs_data == $past(rx_pma_data))
  else $error("rx bypass byte wrong");
a_ready_joint: assert property (!en |-> tx_pcs_ready)
  else $error("ready low while bypassed");
a_oh_no_take: assert property (
  en && tx_overhead_serial_port_frame |-> (!tx_pcs_ready)[*8])
  else $error("payload taken in overhead");
a_payload_start: assert property (
  en && tx_overhead_serial_port_frame |-> ##RDY tx_pcs_ready && !$past(tx_pcs_ready))
  else $error("payload start column wrong");
a_tx_gap: assert property (
  tx_overhead_serial_port_frame |=> (!tx_overhead_serial_port_frame)[*8])
  else $error("tx frame pulse too close");
a_rx_gap: assert property (
  rx_overhead_serial_port_frame |=> (!rx_overhead_serial_port_frame)[*8])
  else $error("rx frame pulse too close");
a_irq_masked: assert property (msk == 3'h0 |-> !irq)
  else $error("irq while fully masked");
c_enabled: cover property (en && tx_overhead_serial_port_frame);
c_rx_frame: cover property (rx_overhead_serial_port_frame);
c_irq: cover property (irq);
endmodule
bind wsf_framer wsf_framer_properties #(.STS_N(STS_N)) u_wsf_framer_properties (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .irq,
  .tx_pcs_data, .tx_pcs_ready, .tx_pma_data, .rx_pma_data, .rx_pcs_data, .rx_pcs_valid,
  .tx_overhead_serial_port_frame, .rx_overhead_serial_port_frame);

// ---- bench/wsf_pcs_pma_model.sv ----
`timescale 1ns/1ns
module wsf_pcs_pma_model
(
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       tx_pcs_ready,
  input  wire [7:0] tx_pma_data,
  output reg  [7:0] tx_pcs_data,
  output reg  [7:0] rx_pma_data
);
// Counting source makes lost or doubled bytes visible downstream
always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    tx_pcs_data <= 8'h00;
    rx_pma_data <= 8'h00;
  end
  else
  begin
    if (tx_pcs_ready)
      tx_pcs_data <= tx_pcs_data + 8'h01;
    rx_pma_data <= tx_pma_data;
  end
end
endmodule

// ---- core/wsf_framer.v ----
`timescale 1ns/1ns
`include "wsf_defs.vh"
module wsf_framer
#(
  parameter [15:0] STS_N           = `WSF_STS_N,
  parameter [15:0] ROW_LEN         = `WSF_ROW_LEN,
  parameter [15:0] B1_LATCH_FRAMES = `WSF_B1_LATCH_FRAMES
)
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  output wire        irq,
  input  wire [7:0]  tx_pcs_data,
  output wire        tx_pcs_ready,
  output reg  [7:0]  tx_pma_data,
  input  wire [7:0]  rx_pma_data,
  output reg  [7:0]  rx_pcs_data,
  output reg         rx_pcs_valid,
  input  wire        tx_overhead_serial_port_sel,
  input  wire        tx_overhead_serial_port_data,
  output reg         tx_overhead_serial_port_frame,
  output wire        rx_overhead_serial_port_data,
  output reg         rx_overhead_serial_port_frame
);

  localparam [15:0] C_A2  = STS_N;
  localparam [15:0] C_J0  = STS_N + STS_N;
  localparam [15:0] C_POH = STS_N + STS_N + STS_N;

  function [19:0] pos_next;
    input [3:0]  r;
    input [15:0] c;
    begin
      if (c == ROW_LEN - 16'd1)
        pos_next = {((r == `WSF_LAST_ROW) ? 4'd0 : r + 4'd1), 16'd0};
      else
        pos_next = {r, c + 16'd1};
    end
  endfunction

  function [6:0] trace_len;
    input [1:0] code;
    begin
      case (code)
        2'd0:    trace_len = 7'd1;
        2'd1:    trace_len = 7'd16;
        default: trace_len = 7'd64;
      endcase
    end
  endfunction

  function [7:0] byte_at;
    input [23:0] w;
    input [4:0]  sh;
    reg   [23:0] t;
    begin
      t = w >> sh;
      byte_at = t[7:0];
    end
  endfunction

  function [3:0] popcount;
    input [7:0] b;
    integer     i;
    begin
      popcount = 4'd0;
      for (i = 0; i < 8; i = i + 1)
        popcount = popcount + {3'd0, b[i]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  reg  [4:0]  ctrl;
  reg  [15:0] framing_octets_tx_reg;
  reg  [15:0] growth_orderwire_tx_reg;
  reg  [15:0] user_channel_dcc_tx_reg;
  reg  [15:0] dcc_tail_tx_reg;
  reg  [2:0]  int_stat;
  reg  [2:0]  int_mask;
  reg  [15:0] section_parity_error_count;
  reg  [7:0]  tx_trace [0:63];
  reg  [7:0]  rx_trace [0:63];
  reg         dp_wr;
  reg  [7:0]  dp_addr;
  reg  [31:0] rd_val;
  wire        en = ctrl[`WSF_CTRL_EN];
  wire        ap_ok = hsel & htrans[1] & hready;
  wire [2:0]  int_set;
  reg  [9:0]  rx_pointer;
  reg         locked;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(int_stat & int_mask);

  always @*
  begin
    rd_val = 32'h0000_0000;
    if (haddr[31:8] == 24'h000000)
    begin
      if (haddr[7:6] == `WSF_TRACE_TX_PAGE)
        rd_val = {tx_trace[{haddr[5:2], 2'd3}], tx_trace[{haddr[5:2], 2'd2}],
                  tx_trace[{haddr[5:2], 2'd1}], tx_trace[{haddr[5:2], 2'd0}]};
      else if (haddr[7:6] == `WSF_TRACE_RX_PAGE)
        rd_val = {rx_trace[{haddr[5:2], 2'd3}], rx_trace[{haddr[5:2], 2'd2}],
                  rx_trace[{haddr[5:2], 2'd1}], rx_trace[{haddr[5:2], 2'd0}]};
      else
        case (haddr[7:0])
          `WSF_REG_CTRL:     rd_val = {27'd0, ctrl};
          `WSF_REG_STATUS:   rd_val = {30'd0, locked, en};
          `WSF_REG_FRAMING:  rd_val = {16'd0, framing_octets_tx_reg};
          `WSF_REG_GROWTH:   rd_val = {16'd0, growth_orderwire_tx_reg};
          `WSF_REG_USERDCC:  rd_val = {16'd0, user_channel_dcc_tx_reg};
          `WSF_REG_DCCTAIL:  rd_val = {16'd0, dcc_tail_tx_reg};
          `WSF_REG_B1CNT:    rd_val = {16'd0, section_parity_error_count};
          `WSF_REG_INT_STAT: rd_val = {29'd0, int_stat};
          `WSF_REG_INT_MASK: rd_val = {29'd0, int_mask};
          `WSF_REG_POINTER:  rd_val = {22'd0, rx_pointer};
          default:           rd_val = 32'h0000_0000;
        endcase
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr                   <= 1'b0;
      dp_addr                 <= 8'h00;
      hrdata                  <= 32'h0000_0000;
      ctrl                    <= 5'd0;
      framing_octets_tx_reg   <= {`WSF_RST_A1, `WSF_RST_A2};
      growth_orderwire_tx_reg <= {`WSF_RST_Z0, `WSF_RST_E1};
      user_channel_dcc_tx_reg <= {`WSF_RST_F1, `WSF_RST_DCC};
      dcc_tail_tx_reg         <= {`WSF_RST_DCC, `WSF_RST_DCC};
      int_mask                <= 3'd0;
      int_stat                <= 3'd0;
    end
    else
    begin
      dp_wr   <= ap_ok & hwrite & (haddr[31:8] == 24'h000000);
      dp_addr <= haddr[7:0];
      if (ap_ok & ~hwrite)
        hrdata <= rd_val;
      // New events win over a simultaneous write-one-to-clear
      if (dp_wr && dp_addr == `WSF_REG_INT_STAT)
        int_stat <= (int_stat & ~hwdata[2:0]) | int_set;
      else
        int_stat <= int_stat | int_set;
      if (dp_wr)
        case (dp_addr)
          `WSF_REG_CTRL:     ctrl <= hwdata[4:0];
          `WSF_REG_FRAMING:  framing_octets_tx_reg <= hwdata[15:0];
          `WSF_REG_GROWTH:   growth_orderwire_tx_reg <= hwdata[15:0];
          `WSF_REG_USERDCC:  user_channel_dcc_tx_reg <= hwdata[15:0];
          `WSF_REG_DCCTAIL:  dcc_tail_tx_reg <= hwdata[15:0];
          `WSF_REG_INT_MASK: int_mask <= hwdata[2:0];
          default:           ;
        endcase
    end
  end

  // Transmit trace memory has no reset; software loads it before enabling
  always @(posedge hclk)
  begin
    if (dp_wr && dp_addr[7:6] == `WSF_TRACE_TX_PAGE)
    begin
      tx_trace[{dp_addr[5:2], 2'd0}] <= hwdata[7:0];
      tx_trace[{dp_addr[5:2], 2'd1}] <= hwdata[15:8];
      tx_trace[{dp_addr[5:2], 2'd2}] <= hwdata[23:16];
      tx_trace[{dp_addr[5:2], 2'd3}] <= hwdata[31:24];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit
  reg  [3:0]  t_row;
  reg  [15:0] t_col;
  reg  [71:0] port_sr;
  reg  [6:0]  port_cnt;
  reg  [71:0] sh;
  reg  [5:0]  tx_tidx;
  reg  [7:0]  tx_b1_acc;
  reg  [7:0]  tx_b1_prev;
  reg  [7:0]  b3_acc;
  reg  [7:0]  b3_prev;
  reg  [7:0]  tx_raw;
  reg         pay_tx;
  reg  [3:0]  poh_i;
  wire [7:0]  tx_scr;
  wire        tx_last = (t_row == `WSF_LAST_ROW) && (t_col == ROW_LEN - 16'd1);
  wire [6:0]  tx_len = trace_len(ctrl[`WSF_CTRL_TXLEN]);
  wire [19:0] t_next = pos_next(t_row, t_col);

  assign tx_pcs_ready = en ? pay_tx : 1'b1;

  // Overhead and payload multiplexer for the current slot
  always @*
  begin
    tx_raw = 8'h00;
    pay_tx = 1'b0;
    poh_i  = (t_row >= 4'd3) ? t_row - 4'd3 : t_row + 4'd6;
    if (t_col < C_POH)
      case (t_row)
        4'd0:
          if (t_col < C_A2)
            tx_raw = sh[71:64];
          else if (t_col < C_J0)
            tx_raw = sh[63:56];
          else if (t_col == C_J0)
            tx_raw = tx_trace[tx_tidx];
          else
            tx_raw = sh[55:48];
        4'd1:
          if (t_col == 16'd0)
            tx_raw = tx_b1_prev ^ sh[7:0];
          else if (t_col == C_A2)
            tx_raw = sh[47:40];
          else if (t_col == C_J0)
            tx_raw = sh[39:32];
        4'd2:
          if (t_col == 16'd0)
            tx_raw = sh[31:24];
          else if (t_col == C_A2)
            tx_raw = sh[23:16];
          else if (t_col == C_J0)
            tx_raw = sh[15:8];
        4'd3:
          if (t_col == 16'd0)
            tx_raw = `WSF_H1;
          else if (t_col < C_A2)
            tx_raw = `WSF_H1_CONCAT;
          else if (t_col == C_A2)
            tx_raw = `WSF_H2;
          else if (t_col < C_J0)
            tx_raw = `WSF_H2_CONCAT;
        default: ;
      endcase
    else if (t_col == C_POH)
      case (poh_i)
        4'd1:    tx_raw = b3_prev;
        4'd2:    tx_raw = `WSF_C2;
        default: tx_raw = 8'h00;
      endcase
    else
    begin
      pay_tx = 1'b1;
      tx_raw = tx_pcs_data;
    end
  end

  wsf_scrambler u_tx_scr
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hold    (~en | ((t_row == 4'd0) & (t_col < C_POH))),
    .din     (tx_raw),
    .dout    (tx_scr)
  );

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      t_row <= 4'd0;
      t_col <= 16'd0;
      sh <= {`WSF_RST_A1, `WSF_RST_A2, `WSF_RST_Z0, `WSF_RST_E1, `WSF_RST_F1,
             `WSF_RST_DCC, `WSF_RST_DCC, `WSF_RST_DCC, 8'h00};
      port_sr <= 72'd0;
      port_cnt <= `WSF_OH_BITS;
      tx_tidx <= 6'd0;
      tx_b1_acc <= 8'h00;
      tx_b1_prev <= 8'h00;
      b3_acc <= 8'h00;
      b3_prev <= 8'h00;
      tx_pma_data <= 8'h00;
      tx_overhead_serial_port_frame <= 1'b0;
    end
    else
    begin
      tx_pma_data <= en ? tx_scr : tx_pcs_data;
      t_row <= en ? t_next[19:16] : 4'd0;
      t_col <= en ? t_next[15:0] : 16'd0;
      tx_overhead_serial_port_frame <= en & tx_last;
      if (port_cnt != `WSF_OH_BITS)
      begin
        port_sr <= {port_sr[70:0], tx_overhead_serial_port_data};
        port_cnt <= port_cnt + 7'd1;
      end
      if (!en || tx_last)
      begin
        // Static per frame unless the port supplies fresh values
        sh <= tx_overhead_serial_port_sel ? port_sr
            : {framing_octets_tx_reg, growth_orderwire_tx_reg,
               user_channel_dcc_tx_reg, dcc_tail_tx_reg, 8'h00};
        port_cnt <= 7'd0;
        tx_b1_prev <= tx_b1_acc ^ tx_scr;
        tx_b1_acc <= 8'h00;
      end
      else
        tx_b1_acc <= tx_b1_acc ^ tx_scr;
      if (t_row == 4'd0 && t_col == C_J0)
        tx_tidx <= ({1'b0, tx_tidx} >= tx_len - 7'd1) ? 6'd0 : tx_tidx + 6'd1;
      if (t_row == 4'd3 && t_col == C_POH)
      begin
        b3_prev <= b3_acc;
        b3_acc <= tx_raw;
      end
      else if (t_col >= C_POH)
        b3_acc <= b3_acc ^ tx_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive
  reg  [7:0]  rx_d1;
  reg  [7:0]  rx_d2;
  reg  [2:0]  off;
  reg  [2:0]  miss;
  reg  [3:0]  r_row;
  reg  [15:0] r_col;
  reg         hunt_hit;
  reg  [2:0]  hunt_off;
  reg  [3:0]  k;
  reg  [7:0]  rx_b1_acc;
  reg  [7:0]  rx_b1_prev;
  reg  [7:0]  b1_err;
  reg  [15:0] b1_run;
  reg  [15:0] frm_cnt;
  reg  [7:0]  rx_h1;
  reg  [63:0] cap;
  reg  [71:0] rx_sr;
  reg  [5:0]  rx_tidx;
  integer     j;
  reg         ev_lof;
  reg         ev_b1;
  reg         ev_ptr;
  wire [23:0] w24 = {rx_d2, rx_d1, rx_pma_data};
  wire [7:0]  ab_cur = byte_at(w24, 5'd8 - {2'd0, off});
  wire [7:0]  ab_prev = byte_at(w24, 5'd16 - {2'd0, off});
  wire [7:0]  rx_desc;
  wire [19:0] r_next = pos_next(r_row, r_col);
  wire        r_last = (r_row == `WSF_LAST_ROW) && (r_col == ROW_LEN - 16'd1);
  wire [6:0]  rx_len = trace_len(ctrl[`WSF_CTRL_RXLEN]);

  assign int_set = {ev_ptr, ev_b1, ev_lof};
  assign rx_overhead_serial_port_data = rx_sr[71];

  // Search all eight bit offsets for the last A1 / first A2 pair
  always @*
  begin
    hunt_hit = 1'b0;
    hunt_off = 3'd0;
    for (k = 4'd7; k != 4'hf; k = k - 4'd1)
      if (byte_at(w24, 5'd16 - {1'b0, k}) == `WSF_RST_A1 &&
          byte_at(w24, 5'd8 - {1'b0, k}) == `WSF_RST_A2)
      begin
        hunt_hit = 1'b1;
        hunt_off = k[2:0];
      end
  end

  wsf_scrambler u_rx_scr
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hold    (~locked | ((r_row == 4'd0) & (r_col < C_POH))),
    .din     (ab_cur),
    .dout    (rx_desc)
  );

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {rx_d1, rx_d2, off, miss, r_row, r_col} <= 42'd0;
      locked <= 1'b0;
      {rx_b1_acc, rx_b1_prev, b1_err, rx_h1} <= 32'd0;
      {b1_run, frm_cnt, section_parity_error_count} <= 48'd0;
      rx_pointer <= 10'd0;
      cap <= 64'd0;
      rx_sr <= 72'd0;
      rx_tidx <= 6'd0;
      // Cleared so bytes beyond a short trace read as zero, not unknown
      for (j = 0; j < 64; j = j + 1)
        rx_trace[j] <= 8'h00;
      {ev_lof, ev_b1, ev_ptr} <= 3'd0;
      rx_pcs_data <= 8'h00;
      rx_pcs_valid <= 1'b0;
      rx_overhead_serial_port_frame <= 1'b0;
    end
    else
    begin
      rx_d1 <= rx_pma_data;
      rx_d2 <= rx_d1;
      {ev_lof, ev_b1, ev_ptr} <= 3'd0;
      rx_pcs_data <= en ? rx_desc : rx_pma_data;
      rx_pcs_valid <= en ? (locked && r_col > C_POH) : 1'b1;
      rx_overhead_serial_port_frame <= locked & r_last;
      rx_sr <= (locked & r_last) ? {cap, b1_err} : {rx_sr[70:0], 1'b0};
      if (!en)
      begin
        locked <= 1'b0;
        miss <= 3'd0;
      end
      else if (!locked)
      begin
        if (hunt_hit)
        begin
          locked <= 1'b1;
          off <= hunt_off;
          r_row <= 4'd0;
          r_col <= C_A2 + 16'd1;
          miss <= 3'd0;
        end
      end
      else
      begin
        r_row <= r_next[19:16];
        r_col <= r_next[15:0];
        if (r_row == 4'd0 && r_col == C_A2)
        begin
          if (ab_prev == `WSF_RST_A1 && ab_cur == `WSF_RST_A2)
            miss <= 3'd0;
          else if (miss == `WSF_LOCK_EXIT - 3'd1)
          begin
            locked <= 1'b0;
            ev_lof <= 1'b1;
          end
          else
            miss <= miss + 3'd1;
        end
        // Parity runs over the scrambled stream as received
        if (r_last)
        begin
          rx_b1_prev <= rx_b1_acc ^ ab_cur;
          rx_b1_acc <= 8'h00;
          if (frm_cnt == B1_LATCH_FRAMES - 16'd1)
          begin
            section_parity_error_count <= b1_run;
            b1_run <= 16'd0;
            frm_cnt <= 16'd0;
          end
          else
            frm_cnt <= frm_cnt + 16'd1;
        end
        else
          rx_b1_acc <= rx_b1_acc ^ ab_cur;
        case (r_row)
          4'd0:
            if (r_col == 16'd0)
              cap[63:56] <= ab_cur;
            else if (r_col == C_A2)
              cap[55:48] <= ab_cur;
            else if (r_col == C_J0)
            begin
              rx_trace[rx_tidx] <= ab_cur;
              rx_tidx <= ({1'b0, rx_tidx} >= rx_len - 7'd1) ? 6'd0 : rx_tidx + 6'd1;
            end
            else if (r_col == C_J0 + 16'd1)
              cap[47:40] <= ab_cur;
          4'd1:
            if (r_col == 16'd0)
            begin
              b1_err <= rx_desc ^ rx_b1_prev;
              b1_run <= b1_run + {12'd0, popcount(rx_desc ^ rx_b1_prev)};
              ev_b1 <= |(rx_desc ^ rx_b1_prev);
            end
            else if (r_col == C_A2)
              cap[39:32] <= rx_desc;
            else if (r_col == C_J0)
              cap[31:24] <= rx_desc;
          4'd2:
            if (r_col == 16'd0)
              cap[23:16] <= rx_desc;
            else if (r_col == C_A2)
              cap[15:8] <= rx_desc;
            else if (r_col == C_J0)
              cap[7:0] <= rx_desc;
          4'd3:
            if (r_col == 16'd0)
              rx_h1 <= rx_desc;
            else if (r_col == C_A2)
            begin
              rx_pointer <= {rx_h1[1:0], rx_desc};
              ev_ptr <= (rx_pointer != {rx_h1[1:0], rx_desc});
            end
          default: ;
        endcase
      end
    end
  end

endmodule

// ---- core/wsf_scrambler.v ----
`timescale 1ns/1ns
module wsf_scrambler
(
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       hold,
  input  wire [7:0] din,
  output wire [7:0] dout
);

  reg  [6:0]  state;
  wire [14:0] stp;

  // Frame-synchronous x^7+x^6+1, MSB of each byte first
  function [14:0] step;
    input [6:0] s;
    reg   [6:0] t;
    reg   [7:0] ks;
    integer     i;
    begin
      t = s;
      ks = 8'h00;
      for (i = 7; i >= 0; i = i - 1)
      begin
        ks[i] = t[6];
        t = {t[5:0], t[6] ^ t[5]};
      end
      step = {ks, t};
    end
  endfunction

  assign stp  = step(state);
  assign dout = hold ? din : (din ^ stp[14:7]);

  // Held at all ones so the first scrambled byte starts from the seed
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state <= 7'h7f;
    else if (hold)
      state <= 7'h7f;
    else
      state <= stp[6:0];
  end

endmodule

// ---- pkg/wsf_defs.vh ----
// Behaviour
// - Sublayer runs only while software sets the enable bit; otherwise bypassed.
// - A read-only status bit shows whether the sublayer is active.
// - One enable bit switches transmit and receive paths together.
// - Transmit maps PCS bytes into the envelope, scrambles, drives PMA.
// - Transmit generates section, line and path overhead octets every frame.
// - Receive finds octet and frame boundaries, then descrambles the frame.
// - Receive checks overhead, flags loss of frame and parity errors.
// - Receive reads the pointer field into a register; payload is taken at fixed columns, not located by the pointer.
// - Receive extracts payload bytes and hands them to the PCS.
// - Framing octets come from a register (F6/28) or the overhead port.
// - Trace of 1, 16 or 64 bytes sent from, captured into registers.
// - Growth (CC) and orderwire (00) octets from one register or port.
// - User channel and DCC octets from registers (00) or the port.
// - Register overhead values repeat every frame except a 16 or 64 byte trace; the port varies per frame.
// - All 192 first framing slots use A1 field, all second use A2.
`ifndef WSF_DEFS_VH
`define WSF_DEFS_VH

// Frame geometry
`define WSF_STS_N           16'd192
`define WSF_ROW_LEN         16'd17280
`define WSF_LAST_ROW        4'd8
`define WSF_B1_LATCH_FRAMES 16'd8000
`define WSF_LOCK_EXIT       3'd4
`define WSF_OH_BITS         7'd72

// Register byte offsets
`define WSF_REG_CTRL        8'h00
`define WSF_REG_STATUS      8'h04
`define WSF_REG_FRAMING     8'h08
`define WSF_REG_GROWTH      8'h0c
`define WSF_REG_USERDCC     8'h10
`define WSF_REG_DCCTAIL     8'h14
`define WSF_REG_B1CNT       8'h18
`define WSF_REG_INT_STAT    8'h1c
`define WSF_REG_INT_MASK    8'h20
`define WSF_REG_POINTER     8'h24
`define WSF_TRACE_TX_PAGE   2'b01
`define WSF_TRACE_RX_PAGE   2'b10

// Control and interrupt fields
`define WSF_CTRL_EN         0
`define WSF_CTRL_TXLEN      2:1
`define WSF_CTRL_RXLEN      4:3
`define WSF_INT_LOF         0
`define WSF_INT_B1          1
`define WSF_INT_PTR         2

// Reset values of overhead octets
`define WSF_RST_A1          8'hf6
`define WSF_RST_A2          8'h28
`define WSF_RST_Z0          8'hcc
`define WSF_RST_E1          8'h00
`define WSF_RST_F1          8'h00
`define WSF_RST_DCC         8'h00

// Fixed pointer and path overhead
`define WSF_H1              8'h60
`define WSF_H2              8'h00
`define WSF_H1_CONCAT       8'h93
`define WSF_H2_CONCAT       8'hff
`define WSF_C2              8'h1a

`endif
